// ===== common/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
// register byte offsets
`define WDT_LOAD_OFS    12'h000
`define WDT_VALUE_OFS   12'h004
`define WDT_CTRL_OFS    12'h008
`define WDT_STAT_OFS    12'h00C
`define WDT_MASK_OFS    12'h010
`define WDT_LOCK_OFS    12'h014
`define WDT_CMD_OFS     12'h018
// control field positions
`define WDT_CTRL_EN     0
`define WDT_CTRL_RSTEN  1
`define WDT_CTRL_STALL  2
`define WDT_CTRL_INTEN  3
// status field positions
`define WDT_STAT_TMO    0
`define WDT_STAT_RST    1
// command bit: clear pending timeout and reload counter, irq stays until status read
`define WDT_CMD_ICLR    0
// lock key, writes of it unlock, anything else locks
`define WDT_UNLOCK_KEY  32'h1ACCE551
// reset values
`define WDT_LOAD_RST    32'hFFFFFFFF
`define WDT_CTRL_RST    4'h0
`define WDT_MASK_RST    2'h3
`endif

// ===== common/wdt_pkg.sv
package wdt_pkg;
  // control bits collected together
  typedef struct packed {
    logic inten;
    logic stall;
    logic rsten;
    logic en;
  } wdt_ctrl_t;
  // latched event flags
  typedef struct packed {
    logic rst;
    logic tmo;
  } wdt_evt_t;
  // ahb bus phase state
  typedef enum logic [1:0] {
    WDT_IDLE = 2'b01,
    WDT_DATA = 2'b10
  } wdt_phase_t;
endpackage : wdt_pkg

// ===== rtl/wdt_core.sv
`timescale 1ns/1ns
`include "wdt_map.svh"
// How it works
// - reload value copied in at first enable
// - reload write while running loads counter
// - reload of zero while running raises interrupt immediately
// - locked: load and control writes ignored
// - reset enable clear: no reset
// - reset enable set: second timeout resets
// - software reads counter enable state
// - stall clear: count through debug halt
// - stall set: freeze while halted
// - unlock restores config write access
// - current count readable anytime
// - reload value readable separately
// - 32-bit counter, enable enables interrupt
// - second zero before clear asserts reset when reset enable is set
// - interrupt clear reloads and continues
// - lock blocks load and control writes, state readable
module wdt_core
  import wdt_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic         I_SYS_CLK,
  input  wire logic         I_RST_N,
  input  wire logic         I_HSEL,
  input  wire logic [11:0]  I_HADDR,
  input  wire logic [1:0]   I_HTRANS,
  input  wire logic         I_HWRITE,
  input  wire logic [2:0]   I_HSIZE,
  input  wire logic [31:0]  I_HWDATA,
  input  wire logic         I_HREADY,
  input  wire logic         I_DBG_HALT,
  output logic [31:0]       O_HRDATA,
  output logic              O_HREADYOUT,
  output logic              O_HRESP,
  output logic              O_IRQ,
  output logic              O_SYS_RST_REQ
);

  // refuse counter widths the logic cannot serve
  if (CNT_W != 32) begin : g_bad_width
    $error("wdt_core: counter must be 32 bits");
  end

  // debug halt pin synchroniser
  logic       halt_s1_ff;
  logic       halt_s2_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      halt_s1_ff <= 1'b0;
      halt_s2_ff <= 1'b0;
    end else begin
      halt_s1_ff <= I_DBG_HALT;
      halt_s2_ff <= halt_s1_ff;
    end
  end

  // captured address phase
  wdt_phase_t phase_ff;
  logic [11:0] addr_ff;
  logic        wr_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      phase_ff <= WDT_IDLE;
      addr_ff  <= 12'h000;
      wr_ff    <= 1'b0;
    end else begin
      case (phase_ff)
        WDT_IDLE, WDT_DATA: begin
          if (I_HREADY && I_HSEL && I_HTRANS[1]) begin
            phase_ff <= WDT_DATA;
            addr_ff  <= I_HADDR;
            wr_ff    <= I_HWRITE;
          end else begin
            phase_ff <= WDT_IDLE;
          end
        end
        default: phase_ff <= WDT_IDLE;
      endcase
    end
  end

  // zero wait state, always okay
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  function automatic logic hit(input logic [11:0] ofs);
    hit = (phase_ff == WDT_DATA) && (addr_ff == ofs);
  endfunction : hit

  logic wr_load;
  logic wr_ctrl;
  logic wr_lock;
  logic wr_cmd;
  logic rd_stat;
  assign wr_load = wr_ff && hit(`WDT_LOAD_OFS);
  assign wr_ctrl = wr_ff && hit(`WDT_CTRL_OFS);
  assign wr_lock = wr_ff && hit(`WDT_LOCK_OFS);
  assign wr_cmd  = wr_ff && hit(`WDT_CMD_OFS);
  assign rd_stat = !wr_ff && hit(`WDT_STAT_OFS);

  // lock state
  logic locked_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      locked_ff <= 1'b0;
    end else if (wr_lock) begin
      locked_ff <= (I_HWDATA != `WDT_UNLOCK_KEY);
    end
  end

  logic cfg_ok;
  assign cfg_ok = !locked_ff;

  // reload value
  logic [31:0] reload_value_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      reload_value_ff <= `WDT_LOAD_RST;
    end else if (wr_load && cfg_ok) begin
      reload_value_ff <= I_HWDATA;
    end
  end

  // control register
  wdt_ctrl_t ctrl_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      ctrl_ff <= `WDT_CTRL_RST;
    end else if (wr_ctrl && cfg_ok) begin
      ctrl_ff.en    <= I_HWDATA[`WDT_CTRL_EN] | ctrl_ff.en;
      ctrl_ff.rsten <= I_HWDATA[`WDT_CTRL_RSTEN];
      ctrl_ff.stall <= I_HWDATA[`WDT_CTRL_STALL];
      // enabling counter also enables interrupt
      ctrl_ff.inten <= I_HWDATA[`WDT_CTRL_INTEN] | I_HWDATA[`WDT_CTRL_EN] | ctrl_ff.inten;
    end
  end

  // interrupt mask
  wdt_evt_t mask_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      mask_ff <= `WDT_MASK_RST;
    end else if (wr_ff && hit(`WDT_MASK_OFS)) begin
      mask_ff <= I_HWDATA[1:0];
    end
  end

  // counter and timeout
  logic [31:0] count_ff;
  logic        tmo_pend_ff;
  logic        run_step;
  logic        at_zero;
  logic        int_clr;
  logic        zero_load;
  logic        first_tmo;
  logic        second_tmo;
  logic        en_write;
  logic [31:0] nxt_count;
  // first enabling write loads the counter
  assign en_write   = !ctrl_ff.en && wr_ctrl && cfg_ok && I_HWDATA[`WDT_CTRL_EN];
  assign run_step   = ctrl_ff.en && !(ctrl_ff.stall && halt_s2_ff);
  assign at_zero    = (count_ff == 32'h00000000);
  assign int_clr    = wr_cmd && I_HWDATA[`WDT_CMD_ICLR];
  assign zero_load  = wr_load && cfg_ok && (I_HWDATA == 32'h00000000) && ctrl_ff.en;
  assign first_tmo  = (run_step && at_zero && !tmo_pend_ff) || zero_load;
  assign second_tmo = run_step && at_zero && tmo_pend_ff;

  // next count: load write, enable, clear, zero, step
  always_comb begin
    nxt_count = count_ff;
    if (wr_load && cfg_ok && ctrl_ff.en) begin
      nxt_count = I_HWDATA;
    end else if (en_write) begin
      nxt_count = reload_value_ff;
    end else if (int_clr && tmo_pend_ff) begin
      nxt_count = reload_value_ff;
    end else if (run_step && at_zero) begin
      nxt_count = reload_value_ff;
    end else if (run_step) begin
      nxt_count = count_ff - 32'h00000001;
    end
  end

  // down counter register
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      count_ff <= `WDT_LOAD_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // first timeout pending, set wins over clear
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      tmo_pend_ff <= 1'b0;
    end else if (first_tmo) begin
      tmo_pend_ff <= 1'b1;
    end else if (int_clr) begin
      tmo_pend_ff <= 1'b0;
    end
  end

  // system reset request, held until reset
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_SYS_RST_REQ <= 1'b0;
    end else if (second_tmo && ctrl_ff.rsten) begin
      O_SYS_RST_REQ <= 1'b1;
    end
  end

  // sticky status, cleared by read, set wins
  wdt_evt_t stat_ff;
  wdt_evt_t nxt_stat;
  always_comb begin
    nxt_stat     = stat_ff;
    nxt_stat.tmo = (first_tmo && ctrl_ff.inten) || (stat_ff.tmo && !rd_stat);
    nxt_stat.rst = (second_tmo && ctrl_ff.rsten) || (stat_ff.rst && !rd_stat);
  end

  // status register
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      stat_ff <= 2'h0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // interrupt level
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(stat_ff & mask_ff & ~{2{rd_stat}});
    end
  end

  // read data mux, registered at data phase start
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (I_HADDR)
      `WDT_LOAD_OFS:  nxt_rdata = reload_value_ff;
      `WDT_VALUE_OFS: nxt_rdata = count_ff;
      `WDT_CTRL_OFS:  nxt_rdata = {28'h0000000, ctrl_ff};
      `WDT_STAT_OFS:  nxt_rdata = {30'h0000000, stat_ff};
      `WDT_MASK_OFS:  nxt_rdata = {30'h0000000, mask_ff};
      `WDT_LOCK_OFS:  nxt_rdata = {31'h0000000, locked_ff};
      default:        nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_HRDATA <= 32'h00000000;
    end else if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
      O_HRDATA <= nxt_rdata;
    end
  end

endmodule : wdt_core

// ===== verification/wdt_dbg_model.sv
`timescale 1ns/1ns
module wdt_dbg_model (
  input  wire logic i_clk,
  input  wire logic i_halt_req,
  output logic      o_halt
);
  logic [1:0] dly_ff = 2'h0;
  // halt reaches the core two cycles late
  always @(posedge i_clk) begin
    dly_ff <= {dly_ff[0], i_halt_req};
  end
  assign o_halt = dly_ff[1];
endmodule : wdt_dbg_model

// ===== verification/wdt_core_monitor.sv
`timescale 1ns/1ns
`include "wdt_map.svh"
module wdt_core_monitor (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_HSEL,
  input wire logic [11:0] I_HADDR,
  input wire logic [1:0]  I_HTRANS,
  input wire logic        I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic        I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic        O_HREADYOUT,
  input wire logic        O_HRESP,
  input wire logic        O_IRQ,
  input wire logic        O_SYS_RST_REQ
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  logic take;
  logic rd_take;
  logic mask_ph_ff;
  // transfer accepted at this edge
  assign take    = I_HSEL & I_HREADY & I_HTRANS[1];
  assign rd_take = take & ~I_HWRITE;
  // data phase of a mask write
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) mask_ph_ff <= 1'b0;
    else if (I_HREADY) mask_ph_ff <= take & I_HWRITE & (I_HADDR == `WDT_MASK_OFS);
  end
  chk_ready_always: assert property (O_HREADYOUT) else $error("hreadyout low");
  chk_resp_okay: assert property (!O_HRESP) else $error("error response");
  chk_rst_sticky: assert property (O_SYS_RST_REQ |=> O_SYS_RST_REQ) else $error("reset dropped");
  chk_rst_after_irq: assert property ($rose(O_SYS_RST_REQ) |-> $past(O_IRQ)) else $error("reset w/o irq");
  chk_rdata_holds: assert property (!rd_take |=> $stable(O_HRDATA)) else $error("rdata moved");
  chk_unmapped_zero: assert property (rd_take && I_HADDR > `WDT_CMD_OFS |=> O_HRDATA == 32'h0) else $error("unmapped");
  chk_quiet_reset: assert property ($rose(I_RST_N) |-> !O_IRQ && !O_SYS_RST_REQ) else $error("reset outputs");
  chk_mask_gates: assert property (mask_ph_ff && I_HWDATA[1:0] == 2'h0 |-> ##[1:3] !O_IRQ) else $error("mask");
  cover property ($rose(O_IRQ));
  cover property ($rose(O_SYS_RST_REQ));
  cover property (mask_ph_ff && O_IRQ);
endmodule : wdt_core_monitor
bind wdt_core wdt_core_monitor u_mon (.I_SYS_CLK, .I_RST_N, .I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE,
  .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT, .O_HRESP, .O_IRQ, .O_SYS_RST_REQ);

// ===== verification/wdt_core_tb.sv
`timescale 1ns/1ns
`include "wdt_map.svh"
module wdt_core_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hwrite = 1'b0;
  logic        halt_req = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, v;
  logic        hready, hresp, irq, rst_req, halt;
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #20 clk = ~clk;
  wdt_core DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .I_DBG_HALT(halt),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_IRQ(irq), .O_SYS_RST_REQ(rst_req));
  wdt_dbg_model u_dbg (.i_clk(clk), .i_halt_req(halt_req), .o_halt(halt));
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk
  // one word transfer, read data lands in q
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    wr(a, 32'h0, 1'b0);
  endtask : rd
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  // reset values, lock and key
  task automatic t_lock();
    rd(`WDT_LOAD_OFS);
    chk("load rst", q, `WDT_LOAD_RST);
    rd(12'h01C);
    chk("unmapped", q, 32'h0);
    wr(`WDT_LOCK_OFS, 32'h0);
    rd(`WDT_LOCK_OFS);
    chk("locked", q[0], 1'b1);
    wr(`WDT_LOAD_OFS, 32'h7);
    wr(`WDT_CTRL_OFS, 32'h1);
    rd(`WDT_LOAD_OFS);
    chk("load lock", q, `WDT_LOAD_RST);
    rd(`WDT_CTRL_OFS);
    chk("ctrl lock", q, 32'h0);
    wr(`WDT_LOCK_OFS, `WDT_UNLOCK_KEY);
    wr(`WDT_LOAD_OFS, 32'h32);
    rd(`WDT_LOAD_OFS);
    chk("load open", q, 32'h32);
  endtask : t_lock
  // enable, step, first timeout, clear
  task automatic t_run();
    wr(`WDT_CTRL_OFS, 32'h1);
    rd(`WDT_CTRL_OFS);
    chk("ctrl en", q, 32'h9);
    rd(`WDT_VALUE_OFS);
    v = q;
    rd(`WDT_VALUE_OFS);
    chk("step", v - q, 32'h2);
    for (int i = 0; i < 80 && irq !== 1'b1; i++) @(posedge clk);
    chk("first tmo", irq, 1'b1);
    wr(`WDT_CMD_OFS, 32'h1);
    rd(`WDT_VALUE_OFS);
    chk("reloaded", q > 32'h2F, 1'b1);
    repeat (120) @(posedge clk);
    chk("no rst", rst_req, 1'b0);
  endtask : t_run
  // reload while running, count or freeze through halt
  task automatic t_stall(input logic [31:0] ctrl, input logic [31:0] step);
    wr(`WDT_LOAD_OFS, 32'h3E8);
    rd(`WDT_VALUE_OFS);
    chk("reload now", q > 32'h3E0 && q <= 32'h3E8, 1'b1);
    wr(`WDT_CTRL_OFS, ctrl);
    halt_req <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`WDT_VALUE_OFS);
    v = q;
    rd(`WDT_VALUE_OFS);
    chk("halt step", v - q, step);
    halt_req <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`WDT_VALUE_OFS);
    v = q;
    rd(`WDT_VALUE_OFS);
    chk("run step", v - q, 32'h2);
  endtask : t_stall
  // zero reload, mask, second timeout reset
  task automatic t_zero_rst();
    rd(`WDT_STAT_OFS);
    chk("stat", q[0], 1'b1);
    repeat (3) @(posedge clk);
    chk("irq clr", irq, 1'b0);
    wr(`WDT_LOAD_OFS, 32'h0);
    repeat (4) @(posedge clk);
    chk("zero irq", irq, 1'b1);
    wr(`WDT_MASK_OFS, 32'h0);
    repeat (3) @(posedge clk);
    chk("masked", irq, 1'b0);
    wr(`WDT_MASK_OFS, 32'h3);
    wr(`WDT_LOAD_OFS, 32'h1E);
    wr(`WDT_CTRL_OFS, 32'h3);
    for (int i = 0; i < 100 && rst_req !== 1'b1; i++) @(posedge clk);
    chk("rst req", rst_req, 1'b1);
    do_reset();
    chk("rst gone", rst_req, 1'b0);
  endtask : t_zero_rst
  initial begin
    do_reset();
    t_lock();
    t_run();
    t_stall(32'h1, 32'h2);
    t_stall(32'h5, 32'h0);
    t_zero_rst();
    complete_run();
  end
endmodule : wdt_core_tb
